// file: core/hiegm_defines.svh
// How it works
// - enable bit 10 gates dual role latch events
// - enable bit 9 gates isochronous group completion
// - enable bit 8 gates async list completion
// - enable bit 7 gates periodic group completion
// - enable bit 6 gates clock stable event
// - enable bit 5 gates suspend entry event
// - enable bit 3 gates dma end event
// - enable bit 1 gates every frame start
// - cleared completion enable keeps line quiet
// - isochronous or mask, 32 bits, bit per descriptor
// - isochronous or mask one joins or group
// - periodic or mask, 32 bits, bit per descriptor
// - periodic or mask one joins or group
// - masks apply to each type's done map
// - status drives line only while enabled
// - and mask group counts when all done, empty mask never
// - done map bit means descriptor completed
`ifndef HIEGM_DEFINES_SVH
`define HIEGM_DEFINES_SVH

// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define HIEGM_OFS_STATUS   12'h310
`define HIEGM_OFS_ENABLE   12'h314
`define HIEGM_OFS_ISO_OR   12'h318
`define HIEGM_OFS_PER_OR   12'h31C

// ----------------------------------------
// bit positions, shared by status and enable
// ----------------------------------------
`define HIEGM_B_DUAL_ROLE  10
`define HIEGM_B_ISO        9
`define HIEGM_B_ASYNC      8
`define HIEGM_B_PERIODIC   7
`define HIEGM_B_CLK_STABLE 6
`define HIEGM_B_SUSPEND    5
`define HIEGM_B_DMA_END    4'h3
`define HIEGM_B_FRAME      1

// ----------------------------------------
// reset values and masks
// ----------------------------------------
`define HIEGM_RST_WORD     32'h0000_0000
`define HIEGM_ENABLE_VALID 32'h0000_07EA
`define HIEGM_ALL_BYTES    4'hF

`endif

// file: core/hiegm_pkg.sv
// ----------------------------------------
// types shared by the block and its users
// ----------------------------------------
package hiegm_pkg;

	// classic wishbone request from the master
	typedef struct packed {
		logic        cyc;
		logic        stb;
		logic        we;
		logic [11:0] adr;
		logic [3:0]  sel;
		logic [31:0] dat;
	} hiegm_wb_req_t;

	// slave answer
	typedef struct packed {
		logic        ack;
		logic [31:0] dat;
	} hiegm_wb_rsp_t;

	// one schedule type: done map and its and mask
	typedef struct packed {
		logic [31:0] done;
		logic [31:0] and_mask;
	} hiegm_map_t;

	// single-cycle event pulses, dual role is a level
	typedef struct packed {
		logic dual_role;
		logic clk_stable;
		logic suspend;
		logic dma_end;
		logic frame_start;
	} hiegm_evt_t;

	// all state of the block
	typedef struct packed {
		logic [31:0] enable;
		logic [31:0] iso_or;
		logic [31:0] per_or;
		logic [31:0] status;
		logic [31:0] rdat;
		logic        ack;
		logic        irq;
	} hiegm_state_t;

endpackage : hiegm_pkg

// file: core/hiegm_top.sv
`timescale 1ns/1ps
`include "hiegm_defines.svh"

module hiegm_top
	import hiegm_pkg::*;
(
	input  wire logic          mclk,          // system clock
	input  wire logic          sys_rst,       // sync reset, high
	input  wire hiegm_wb_req_t wb_req,        // bus request
	output      hiegm_wb_rsp_t wb_rsp,        // bus answer
	input  wire hiegm_evt_t    evt,           // event sources
	input  wire hiegm_map_t    iso_map,       // isochronous done map
	input  wire hiegm_map_t    periodic_map,  // periodic done map
	input  wire hiegm_map_t    async_map,     // async list done map
	input  wire logic [31:0]   async_or_mask, // async or mask
	output      logic          host_irq       // host interrupt, high
);

	// ----------------------------------------
	// helper functions
	// ----------------------------------------

	// any or-selected descriptor done
	function automatic logic or_hit(input logic [31:0] done, input logic [31:0] msk);
		or_hit = |(done & msk);
	endfunction

	// every and-selected descriptor done, empty mask never fires
	function automatic logic and_hit(input logic [31:0] done, input logic [31:0] msk);
		and_hit = (msk != `HIEGM_RST_WORD) && ((done & msk) == msk);
	endfunction

	// byte-lane merge of write data
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
		input logic [3:0] sel);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (sel[i]) begin
				r[i*8 +: 8] = nw[i*8 +: 8];
			end
		end
		merge = r;
	endfunction

	// word-aligned register address; the two byte bits are dropped here
	// so the decode compares full-width offsets, never a shifted copy
	function automatic logic [11:0] word_adr(input logic [11:0] adr);
		word_adr = {adr[11:2], 2'h0};
	endfunction

	// ----------------------------------------
	// state and decode
	// ----------------------------------------
	hiegm_state_t st_q;      // registered state
	hiegm_state_t st_d;      // next state
	logic         req;       // new access this cycle
	logic         wr;        // write accepted
	logic [31:0]  set_vec;   // hardware sets
	logic [31:0]  clr_vec;   // software clears
	logic         iso_grp;   // isochronous group event
	logic         per_grp;   // periodic group event
	logic         asy_grp;   // async group event

	// ack only once per request, so back-to-back strobes see a gap
	assign req = wb_req.cyc && wb_req.stb && !st_q.ack;
	assign wr  = req && wb_req.we;

	// group events per schedule type
	assign iso_grp = or_hit(iso_map.done, st_q.iso_or)
		|| and_hit(iso_map.done, iso_map.and_mask);
	assign per_grp = or_hit(periodic_map.done, st_q.per_or)
		|| and_hit(periodic_map.done, periodic_map.and_mask);
	assign asy_grp = or_hit(async_map.done, async_or_mask)
		|| and_hit(async_map.done, async_map.and_mask);

	// ----------------------------------------
	// next-state logic
	// ----------------------------------------
	always_comb begin
		st_d    = st_q;
		set_vec = `HIEGM_RST_WORD;
		clr_vec = `HIEGM_RST_WORD;

		// event sources into sticky flags
		set_vec[`HIEGM_B_ISO]        = iso_grp;
		set_vec[`HIEGM_B_ASYNC]      = asy_grp;
		set_vec[`HIEGM_B_PERIODIC]   = per_grp;
		set_vec[`HIEGM_B_CLK_STABLE] = evt.clk_stable;
		set_vec[`HIEGM_B_SUSPEND]    = evt.suspend;
		set_vec[`HIEGM_B_DMA_END]    = evt.dma_end;
		set_vec[`HIEGM_B_FRAME]      = evt.frame_start;

		// writes, each register decoded on its word address
		if (wr) begin
			unique case (word_adr(wb_req.adr))
				`HIEGM_OFS_STATUS: begin
					// write one to clear, lane-gated
					clr_vec = merge(`HIEGM_RST_WORD, wb_req.dat, wb_req.sel);
				end
				`HIEGM_OFS_ENABLE: begin
					// reserved bits never stored, read back zero
					st_d.enable = merge(st_q.enable, wb_req.dat, wb_req.sel)
						& `HIEGM_ENABLE_VALID;
				end
				`HIEGM_OFS_ISO_OR: begin
					st_d.iso_or = merge(st_q.iso_or, wb_req.dat, wb_req.sel);
				end
				`HIEGM_OFS_PER_OR: begin
					st_d.per_or = merge(st_q.per_or, wb_req.dat, wb_req.sel);
				end
				default: begin
					// unmapped write: acked, dropped
				end
			endcase
		end

		// set wins over clear so no event is lost
		st_d.status = ((st_q.status & ~clr_vec) | set_vec) & `HIEGM_ENABLE_VALID;
		// dual role latch lives outside, mirrored as a level
		st_d.status[`HIEGM_B_DUAL_ROLE] = evt.dual_role;

		// read data, unmapped answers zero
		st_d.rdat = `HIEGM_RST_WORD;
		if (req && !wb_req.we) begin
			// lanes gate nothing on a read: the whole word comes back
			unique case (word_adr(wb_req.adr))
				`HIEGM_OFS_STATUS: st_d.rdat = st_q.status;
				`HIEGM_OFS_ENABLE: st_d.rdat = st_q.enable;
				`HIEGM_OFS_ISO_OR: st_d.rdat = st_q.iso_or;
				`HIEGM_OFS_PER_OR: st_d.rdat = st_q.per_or;
				default:                st_d.rdat = `HIEGM_RST_WORD;
			endcase
		end

		// one-cycle ack, then drop
		st_d.ack = req;

		// line is or of enabled flags; a clear enable bit mutes its class
		st_d.irq = |(st_q.status & st_q.enable);
	end

	// ----------------------------------------
	// state register
	// ----------------------------------------
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	// outputs straight from flops
	// one driver for the whole answer struct
	assign wb_rsp     = '{ack: st_q.ack, dat: st_q.rdat};
	assign host_irq   = st_q.irq;

	// ----------------------------------------
	// assertions
	// ----------------------------------------
	default clocking cb @(posedge mclk); endclocking
	default disable iff (sys_rst);

	// interrupt follows enabled flags one cycle later
	property p_irq_follows;
		1'b1 |=> (host_irq == $past(|(st_q.status & st_q.enable)));
	endproperty
	a_irq_follows: assert property (p_irq_follows)
		else $error("irq does not match enabled flags");

	// no enables, no interrupt
	property p_irq_muted;
		(st_q.enable == `HIEGM_RST_WORD) |=> !host_irq;
	endproperty
	a_irq_muted: assert property (p_irq_muted)
		else $error("irq raised with all enables clear");

	// periodic completion muted when its enable is clear
	property p_per_muted;
		(st_q.status == (32'h1 << `HIEGM_B_PERIODIC)) && !st_q.enable[`HIEGM_B_PERIODIC]
			|=> !host_irq;
	endproperty
	a_per_muted: assert property (p_per_muted)
		else $error("periodic completion leaked past enable");

	// dual role level with enable reaches the line in two cycles
	property p_dual_role;
		(evt.dual_role && st_q.enable[`HIEGM_B_DUAL_ROLE])
			##1 st_q.enable[`HIEGM_B_DUAL_ROLE] |=> host_irq;
	endproperty
	a_dual_role: assert property (p_dual_role)
		else $error("dual role event did not raise irq");

	// isochronous or hit sets its flag
	property p_iso_or;
		|(iso_map.done & st_q.iso_or) |=> st_q.status[`HIEGM_B_ISO];
	endproperty
	a_iso_or: assert property (p_iso_or)
		else $error("iso or hit lost");

	// periodic and group complete sets its flag
	property p_per_and;
		(periodic_map.and_mask != `HIEGM_RST_WORD)
			&& ((periodic_map.done & periodic_map.and_mask) == periodic_map.and_mask)
			|=> st_q.status[`HIEGM_B_PERIODIC];
	endproperty
	a_per_and: assert property (p_per_and)
		else $error("periodic and group lost");

	// empty groups never set the periodic flag
	property p_per_empty;
		(st_q.per_or == `HIEGM_RST_WORD) && (periodic_map.and_mask == `HIEGM_RST_WORD)
			&& !st_q.status[`HIEGM_B_PERIODIC] |=> !st_q.status[`HIEGM_B_PERIODIC];
	endproperty
	a_per_empty: assert property (p_per_empty)
		else $error("periodic flag set with empty groups");

	// async or hit sets its flag
	property p_async;
		|(async_map.done & async_or_mask) |=> st_q.status[`HIEGM_B_ASYNC];
	endproperty
	a_async: assert property (p_async)
		else $error("async hit lost");

	// frame start pulse sets its flag, even against a clear
	property p_events;
		evt.frame_start |=> st_q.status[`HIEGM_B_FRAME];
	endproperty
	a_events: assert property (p_events)
		else $error("frame start event lost");

	// full-word write lands in the isochronous or mask
	property p_iso_wr;
		wr && (word_adr(wb_req.adr) == `HIEGM_OFS_ISO_OR) && (wb_req.sel == `HIEGM_ALL_BYTES)
			|=> (st_q.iso_or == $past(wb_req.dat));
	endproperty
	a_iso_wr: assert property (p_iso_wr)
		else $error("iso or mask write lost");

	// ack lasts one cycle
	property p_ack;
		req |=> wb_rsp.ack ##1 !wb_rsp.ack;
	endproperty
	a_ack: assert property (p_ack)
		else $error("ack not a single cycle");

	// dma end pulse sets its flag, even against a clear in the same cycle
	property p_dma_evt;
		evt.dma_end |=> st_q.status[`HIEGM_B_DMA_END];
	endproperty
	a_dma_evt: assert property (p_dma_evt)
		else $error("dma end event lost");

	// clock stable pulse sets its flag
	property p_clk_evt;
		evt.clk_stable |=> st_q.status[`HIEGM_B_CLK_STABLE];
	endproperty
	a_clk_evt: assert property (p_clk_evt)
		else $error("clock stable event lost");

	// suspend entry pulse sets its flag
	property p_susp_evt;
		evt.suspend |=> st_q.status[`HIEGM_B_SUSPEND];
	endproperty
	a_susp_evt: assert property (p_susp_evt)
		else $error("suspend entry event lost");

	// dual role flag mirrors the latch one cycle late, never sticky
	property p_dual_mirror;
		1'b1 |=> (st_q.status[`HIEGM_B_DUAL_ROLE] == $past(evt.dual_role));
	endproperty
	a_dual_mirror: assert property (p_dual_mirror)
		else $error("dual role flag does not mirror its latch");

	// periodic or hit sets its flag
	property p_per_or;
		|(periodic_map.done & st_q.per_or) |=> st_q.status[`HIEGM_B_PERIODIC];
	endproperty
	a_per_or: assert property (p_per_or)
		else $error("periodic or hit lost");

	// isochronous and group complete sets its flag
	property p_iso_and;
		(iso_map.and_mask != `HIEGM_RST_WORD)
			&& ((iso_map.done & iso_map.and_mask) == iso_map.and_mask)
			|=> st_q.status[`HIEGM_B_ISO];
	endproperty
	a_iso_and: assert property (p_iso_and)
		else $error("iso and group lost");

	// isochronous completion muted when its enable is clear
	property p_iso_muted;
		(st_q.status == (32'h1 << `HIEGM_B_ISO)) && !st_q.enable[`HIEGM_B_ISO]
			|=> !host_irq;
	endproperty
	a_iso_muted: assert property (p_iso_muted)
		else $error("iso completion leaked past enable");

	// reserved enable bits never hold a one
	property p_rsvd;
		(st_q.enable & ~`HIEGM_ENABLE_VALID) == `HIEGM_RST_WORD;
	endproperty
	a_rsvd: assert property (p_rsvd)
		else $error("reserved enable bit stored");

	// full-word write lands in the periodic or mask
	property p_per_wr;
		wr && (word_adr(wb_req.adr) == `HIEGM_OFS_PER_OR) && (wb_req.sel == `HIEGM_ALL_BYTES)
			|=> (st_q.per_or == $past(wb_req.dat));
	endproperty
	a_per_wr: assert property (p_per_wr)
		else $error("periodic or mask write lost");

	// isochronous or mask reads back what it holds
	property p_iso_rd;
		req && !wb_req.we && (word_adr(wb_req.adr) == `HIEGM_OFS_ISO_OR)
			|=> (wb_rsp.dat == $past(st_q.iso_or));
	endproperty
	a_iso_rd: assert property (p_iso_rd)
		else $error("iso or mask read wrong");

	// write one clears a flag when no event sets it again
	property p_w1c;
		wr && (word_adr(wb_req.adr) == `HIEGM_OFS_STATUS) && wb_req.sel[0]
			&& wb_req.dat[`HIEGM_B_CLK_STABLE] && !evt.clk_stable
			|=> !st_q.status[`HIEGM_B_CLK_STABLE];
	endproperty
	a_w1c: assert property (p_w1c)
		else $error("status flag not cleared");

	// read data idles at zero outside ack
	property p_rdat_idle;
		!wb_rsp.ack |-> (wb_rsp.dat == `HIEGM_RST_WORD);
	endproperty
	a_rdat_idle: assert property (p_rdat_idle)
		else $error("read data not zero outside ack");

	// covers for the main scenarios
	c_irq: cover property (!host_irq ##1 host_irq);
	c_and: cover property (and_hit(periodic_map.done, periodic_map.and_mask));
	c_clr: cover property (wr && (word_adr(wb_req.adr) == `HIEGM_OFS_STATUS) && |st_q.status);
	c_dual: cover property (evt.dual_role && st_q.enable[`HIEGM_B_DUAL_ROLE]);
	c_mute: cover property (|st_q.status && (st_q.enable == `HIEGM_RST_WORD));

endmodule // hiegm_top

// file: sim/hiegm_tb.sv
`timescale 1ns/1ps
`include "hiegm_defines.svh"

module tb;
	import hiegm_pkg::*;

	// ----------------------------------------
	// stimulus and observed signals
	// ----------------------------------------
	logic          mclk;          // 100 MHz system clock
	logic          sys_rst;       // sync reset, high
	hiegm_wb_req_t wb_req;        // bus request, bench driven
	hiegm_wb_rsp_t wb_rsp;        // bus answer
	hiegm_evt_t    evt;           // event sources
	hiegm_map_t    iso_map;       // isochronous done map
	hiegm_map_t    periodic_map;  // periodic done map
	hiegm_map_t    async_map;     // async list done map
	logic [31:0]   async_or_mask; // async or mask input
	logic          host_irq;      // host interrupt line
	int            bad_count;     // mismatches seen
	int            n_compared;    // comparisons made
	logic [31:0]   rd;            // last read word
	int            src_bit[8] = '{10, 9, 8, 7, 6, 5, 3, 1}; // status bit per source

	hiegm_top dut_u (
		.mclk          (mclk),
		.sys_rst       (sys_rst),
		.wb_req        (wb_req),
		.wb_rsp        (wb_rsp),
		.evt           (evt),
		.iso_map       (iso_map),
		.periodic_map  (periodic_map),
		.async_map     (async_map),
		.async_or_mask (async_or_mask),
		.host_irq      (host_irq)
	);

	// ----------------------------------------
	// clock
	// ----------------------------------------
	initial begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end

	// ----------------------------------------
	// helper tasks
	// ----------------------------------------
	// verdict and end of run, single exit point
	task give_verdict;
		$display("comparisons %0d, mismatches %0d", n_compared, bad_count);
		if (bad_count == 0 && n_compared > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	// one comparison, four-state exact
	task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			bad_count++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask

	// classic cycle; entered just after a rising edge, bounded wait on ack
	task wb_xfer(input logic we, input logic [11:0] a, input logic [3:0] s, input logic [31:0] d);
		int i;
		wb_req <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: a, sel: s, dat: d};
		i = 0;
		do begin
			@(posedge mclk);
			i++;
		end while (wb_rsp.ack !== 1'b1 && i < 20);
		if (wb_rsp.ack === 1'b1) begin
			rd = wb_rsp.dat;
			wb_req <= '0;
			@(posedge mclk);
		end else begin
			bad_count++;
			give_verdict();
		end
	endtask

	// read a register and compare
	task rd_chk(input string what, input logic [11:0] a, input logic [31:0] exp);
		wb_xfer(1'b0, a, 4'h0, 32'h0000_0000);
		check(what, rd, exp);
	endtask

	// drive one event source; group sources go through descriptor 0
	task set_src(input int b, input logic v);
		case (b)
			10: evt.dual_role <= v;
			9: iso_map.done <= {31'h0000_0000, v};
			8: async_map.done <= {31'h0000_0000, v};
			7: periodic_map.done <= {31'h0000_0000, v};
			6: evt.clk_stable <= v;
			5: evt.suspend <= v;
			3: evt.dma_end <= v;
			default: evt.frame_start <= v;
		endcase
	endtask

	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		sys_rst = 1'b1;
		wb_req = '0;
		evt = '0;
		iso_map = '0;
		periodic_map = '0;
		async_map = '0;
		async_or_mask = 32'h0000_0000;
		bad_count = 0;
		n_compared = 0;
		repeat (8) @(posedge mclk);
		sys_rst <= 1'b0;
		@(posedge mclk);
		// reset values of all masks and the enable
		rd_chk("enable_rst", `HIEGM_OFS_ENABLE, 32'h0000_0000);
		rd_chk("iso_or_rst", `HIEGM_OFS_ISO_OR, 32'h0000_0000);
		rd_chk("per_or_rst", `HIEGM_OFS_PER_OR, 32'h0000_0000);
		check("irq_rst", {31'h0, host_irq}, 32'h0000_0000);
		// full width of the two or masks, byte lanes of the iso or mask only
		wb_xfer(1'b1, `HIEGM_OFS_ISO_OR, 4'h2, 32'hFFFF_FFFF);
		rd_chk("iso_or_lane", `HIEGM_OFS_ISO_OR, 32'h0000_FF00);
		wb_xfer(1'b1, `HIEGM_OFS_ISO_OR, 4'hF, 32'hA5C3_5A3C);
		rd_chk("iso_or_rw", `HIEGM_OFS_ISO_OR, 32'hA5C3_5A3C);
		wb_xfer(1'b1, `HIEGM_OFS_PER_OR, 4'hF, 32'h8000_0001);
		rd_chk("per_or_rw", `HIEGM_OFS_PER_OR, 32'h8000_0001);
		wb_xfer(1'b1, `HIEGM_OFS_ENABLE, 4'hF, 32'h0000_07EA);
		rd_chk("enable_rw", `HIEGM_OFS_ENABLE, 32'h0000_07EA);
		// unmapped place: write dropped, reads zero
		wb_xfer(1'b1, 12'h400, 4'hF, 32'hFFFF_FFFF);
		rd_chk("unmapped", 12'h400, 32'h0000_0000);
		// descriptor 0 selects each or group
		wb_xfer(1'b1, `HIEGM_OFS_ENABLE, 4'hF, 32'h0000_0000);
		wb_xfer(1'b1, `HIEGM_OFS_ISO_OR, 4'hF, 32'h0000_0001);
		wb_xfer(1'b1, `HIEGM_OFS_PER_OR, 4'hF, 32'h0000_0001);
		async_or_mask <= 32'h0000_0001;
		// each source, first disabled then enabled; cleared flags drop the line
		for (int k = 0; k < 8; k++) begin
			set_src(src_bit[k], 1'b1);
			repeat (4) @(posedge mclk);
			check("irq_disabled", {31'h0, host_irq}, 32'h0000_0000);
			set_src(src_bit[k], 1'b0);
			@(posedge mclk);
			wb_xfer(1'b1, `HIEGM_OFS_STATUS, 4'hF, 32'h1 << src_bit[k]);
			wb_xfer(1'b1, `HIEGM_OFS_ENABLE, 4'hF, 32'h1 << src_bit[k]);
			set_src(src_bit[k], 1'b1);
			repeat (4) @(posedge mclk);
			check("irq_enabled", {31'h0, host_irq}, 32'h0000_0001);
			rd_chk("status_bit", `HIEGM_OFS_STATUS, 32'h1 << src_bit[k]);
			set_src(src_bit[k], 1'b0);
			@(posedge mclk);
			wb_xfer(1'b1, `HIEGM_OFS_STATUS, 4'hF, 32'h1 << src_bit[k]);
			repeat (3) @(posedge mclk);
			check("irq_cleared", {31'h0, host_irq}, 32'h0000_0000);
			wb_xfer(1'b1, `HIEGM_OFS_ENABLE, 4'hF, 32'h0000_0000);
		end
		// descriptor outside the or mask does not fire the iso group
		wb_xfer(1'b1, `HIEGM_OFS_ISO_OR, 4'hF, 32'h0000_0002);
		iso_map.done <= 32'h0000_0001;
		repeat (3) @(posedge mclk);
		rd_chk("iso_or_excl", `HIEGM_OFS_STATUS, 32'h0000_0000);
		// and group: partial completion is quiet, full completion fires
		wb_xfer(1'b1, `HIEGM_OFS_ISO_OR, 4'hF, 32'h0000_0000);
		iso_map.and_mask <= 32'h8000_0001;
		repeat (3) @(posedge mclk);
		rd_chk("and_partial", `HIEGM_OFS_STATUS, 32'h0000_0000);
		iso_map.done <= 32'h8000_0001;
		repeat (3) @(posedge mclk);
		rd_chk("and_full", `HIEGM_OFS_STATUS, 32'h0000_0200);
		// periodic or mask zero bit keeps descriptor 1 out; iso group emptied first, set wins
		periodic_map.done <= 32'h0000_0002;
		iso_map <= '0;
		wb_xfer(1'b1, `HIEGM_OFS_STATUS, 4'hF, 32'h0000_0200);
		repeat (3) @(posedge mclk);
		rd_chk("per_or_excl", `HIEGM_OFS_STATUS, 32'h0000_0000);
		// periodic and group, muted until its enable is set
		periodic_map.and_mask <= 32'h0000_0006;
		repeat (3) @(posedge mclk);
		rd_chk("per_and_part", `HIEGM_OFS_STATUS, 32'h0000_0000);
		periodic_map.done <= 32'h0000_0006;
		repeat (3) @(posedge mclk);
		rd_chk("per_and_full", `HIEGM_OFS_STATUS, 32'h0000_0080);
		check("per_and_muted", {31'h0, host_irq}, 32'h0000_0000);
		wb_xfer(1'b1, `HIEGM_OFS_ENABLE, 4'hF, 32'h0000_0080);
		repeat (3) @(posedge mclk);
		check("per_and_irq", {31'h0, host_irq}, 32'h0000_0001);
		// reset in mid-run wipes enables, masks and the line
		periodic_map <= '0;
		sys_rst <= 1'b1;
		repeat (8) @(posedge mclk);
		sys_rst <= 1'b0;
		@(posedge mclk);
		check("irq_rst2", {31'h0, host_irq}, 32'h0000_0000);
		rd_chk("enable_rst2", `HIEGM_OFS_ENABLE, 32'h0000_0000);
		rd_chk("per_or_rst2", `HIEGM_OFS_PER_OR, 32'h0000_0000);
		rd_chk("status_rst2", `HIEGM_OFS_STATUS, 32'h0000_0000);
		give_verdict();
	end
endmodule // tb
